// file: hw/ucd_regs.vh
// Purpose: constants for the upstream charger detection and downstream charge control block
// Assumes: 200 MHz aclk, AXI4-Lite register access, 32-bit words
// Notes:   offsets are byte addresses of aligned words
`ifndef UCD_REGS_VH
`define UCD_REGS_VH
// ==============================================================
// register offsets
`define UCD_OFF_CTRL        8'h00
`define UCD_OFF_STATUS      8'h04
`define UCD_OFF_IRQ_STATUS  8'h08
`define UCD_OFF_IRQ_CLEAR   8'h0c
`define UCD_OFF_IRQ_ENABLE  8'h10
`define UCD_OFF_CHARGE_EN   8'h14
`define UCD_OFF_PORT_POWER  8'h18
// ==============================================================
// control field positions
`define UCD_CTRL_DETECT_EN   0
`define UCD_CTRL_ENHANCED    1
`define UCD_CTRL_CFG_DONE    2
`define UCD_CTRL_HUB_PWR     3
`define UCD_CTRL_HUB_PWR_LO  4
`define UCD_CTRL_RST_VAL     32'h0000_0001
// ==============================================================
// interrupt bits
`define UCD_IRQ_DONE      0
`define UCD_IRQ_OVERCUR   1
// ==============================================================
// charger kind codes
`define UCD_KIND_NONE     3'h0
`define UCD_KIND_DCP      3'h1
`define UCD_KIND_CDP      3'h2
`define UCD_KIND_SDP      3'h3
// ==============================================================
// timing, ms and cycles at 200 MHz
`define UCD_CLK_KHZ           200000
`define UCD_T_CONTACT_MS      200
`define UCD_T_SOURCE_MS       80
`define UCD_T_END_MS          80
`define UCD_T_EXIT_MS         50
`define UCD_CYC_CONTACT       (`UCD_T_CONTACT_MS * `UCD_CLK_KHZ)
`define UCD_CYC_SOURCE        (`UCD_T_SOURCE_MS * `UCD_CLK_KHZ)
`define UCD_CYC_END           (`UCD_T_END_MS * `UCD_CLK_KHZ)
`define UCD_CYC_EXIT          (`UCD_T_EXIT_MS * `UCD_CLK_KHZ)
`define UCD_NPORTS            3
`endif

// file: hw/ucd_sync.v
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to aclk
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
module ucd_sync #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  input  wire [W-1:0] rst_val,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      // reset to the pins' idle levels, else a false event follows reset
      meta_ff <= rst_val;
      dout    <= rst_val;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // ucd_sync

// file: hw/ucd_top.v
// Purpose: upstream charger detection sequencer and downstream charge power control
// Assumes: analog comparators deliver levels on pins; 200 MHz aclk
// Notes:   timer lengths are parameters so simulation can shorten them
// Overview of operation
// [R1] detection starts itself on entering detect stage
// [R2] data lines released while detection disabled
// [R3] kind codes 001 dcp 010 cdp 011 sdp
// [R4] enhanced mode separates cdp from dcp
// [R5] result in status register plus interrupt
// [R6] timers 200, 80, 80, 50 ms
// [R7] handles bc1.1 and shorted-line chargers alike
// [R8] every downstream port may join charging
// [R9] hub only acknowledges, never sources current
// [R10] charging chosen separately per port
// [R11] enable bit n is port n, powers it; here enable bit n+1 powers port n and bit 0 is unused
// [R12] charge logic owns power until hub feature set
// [R13] overcurrent clears power; charge side needs reset
// [R14] timers count clock within tolerance windows
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "ucd_regs.vh"
module ucd_top #(
  parameter [31:0] CYC_CONTACT = `UCD_CYC_CONTACT,
  parameter [31:0] CYC_SOURCE  = `UCD_CYC_SOURCE,
  parameter [31:0] CYC_END     = `UCD_CYC_END,
  parameter [31:0] CYC_EXIT    = `UCD_CYC_EXIT
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        charger_detect_stage,
  input  wire        contact_sense,
  input  wire        dat_det_sense,
  input  wire        short_sense,
  input  wire [2:0]  overcurrent_sense_n,
  output reg         dp_src_en_ff,
  output reg         dm_sink_en_ff,
  output reg         dp_oe_ff,
  output reg         dm_oe_ff,
  output reg  [2:0]  port_power_bit,
  output reg  [2:0]  charge_ack_en_ff,
  output reg         irq_ff
);
  // ==============================================================
  // pin synchronisers
  wire [6:0] pins_s;
  ucd_sync #(.W(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({overcurrent_sense_n, short_sense, dat_det_sense,
                contact_sense, charger_detect_stage}),
    .rst_val (7'h70), // overcurrent pins idle high
    .dout    (pins_s)
  );
  wire       stage_s   = pins_s[0];
  wire       contact_s = pins_s[1];
  wire       datdet_s  = pins_s[2];
  wire       short_s   = pins_s[3];
  wire [2:0] overcurrent_sense_n_s   = pins_s[6:4];

  // ==============================================================
  // registers
  reg  [31:0] ctrl_ff;
  reg  [2:0]  kind_ff;
  reg         done_ff;
  reg  [1:0]  irq_sts_ff;
  reg  [1:0]  irq_en_ff;
  reg  [3:0]  charge_en_ff;
  reg         stage_d_ff;
  wire        det_en    = ctrl_ff[`UCD_CTRL_DETECT_EN];
  wire        enhanced  = ctrl_ff[`UCD_CTRL_ENHANCED];
  wire        cfg_done  = ctrl_ff[`UCD_CTRL_CFG_DONE];
  wire        hub_pwr   = ctrl_ff[`UCD_CTRL_HUB_PWR];
  wire [2:0]  hub_power = {ctrl_ff[`UCD_CTRL_HUB_PWR_LO+2], ctrl_ff[`UCD_CTRL_HUB_PWR_LO+1],
                           ctrl_ff[`UCD_CTRL_HUB_PWR_LO]};

  // ==============================================================
  // detection state machine
  localparam [6:0] ST_IDLE    = 7'h01;
  localparam [6:0] ST_CONTACT = 7'h02;
  localparam [6:0] ST_SOURCE  = 7'h04;
  localparam [6:0] ST_SECOND  = 7'h08;
  localparam [6:0] ST_END     = 7'h10;
  localparam [6:0] ST_EXIT    = 7'h20;
  localparam [6:0] ST_DONE    = 7'h40;
  reg  [6:0]  state_ff;
  reg  [6:0]  nxt_state;
  reg  [31:0] tmr_ff;
  reg  [31:0] nxt_tmr;
  reg  [2:0]  nxt_kind;
  reg         done_evt;
  wire        tmr_zero = (tmr_ff == 32'h0000_0000);
  wire        stage_rise = stage_s & ~stage_d_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_tmr   = tmr_zero ? tmr_ff : tmr_ff - 32'h0000_0001; // R14
    nxt_kind  = kind_ff;
    done_evt  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (stage_rise && det_en) begin // R1
          nxt_state = ST_CONTACT;
          nxt_tmr   = CYC_CONTACT - 32'h0000_0001; // R6
          nxt_kind  = `UCD_KIND_NONE;
        end
      end
      ST_CONTACT: begin
        // timeout also proceeds: non-compliant chargers lack contact pins
        if (contact_s || tmr_zero) begin // R7
          nxt_state = ST_SOURCE;
          nxt_tmr   = CYC_SOURCE - 32'h0000_0001; // R6
        end
      end
      ST_SOURCE: begin
        if (tmr_zero) begin
          if (short_s) begin
            nxt_kind = `UCD_KIND_DCP; // R3 R7
          end else if (datdet_s) begin
            nxt_kind = `UCD_KIND_DCP; // R3
          end else begin
            nxt_kind = `UCD_KIND_SDP; // R3
          end
          if (datdet_s && enhanced && !short_s) begin // R4
            nxt_state = ST_SECOND;
            nxt_tmr   = CYC_SOURCE - 32'h0000_0001;
          end else begin
            nxt_state = ST_END;
            nxt_tmr   = CYC_END - 32'h0000_0001; // R6
          end
        end
      end
      ST_SECOND: begin
        if (tmr_zero) begin
          // reflection gone with dp source off and dm sink on means downstream charging port
          nxt_kind  = datdet_s ? `UCD_KIND_DCP : `UCD_KIND_CDP; // R4
          nxt_state = ST_END;
          nxt_tmr   = CYC_END - 32'h0000_0001;
        end
      end
      ST_END: begin
        if (tmr_zero) begin
          nxt_state = ST_DONE;
          done_evt  = 1'b1; // R5
        end
      end
      ST_EXIT: begin
        if (tmr_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (!stage_s) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!det_en && state_ff != ST_IDLE && state_ff != ST_EXIT) begin
      nxt_state = ST_EXIT;
      nxt_tmr   = CYC_EXIT - 32'h0000_0001; // R6
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ST_IDLE;
      tmr_ff        <= 32'h0000_0000;
      kind_ff       <= `UCD_KIND_NONE;
      done_ff       <= 1'b0;
      stage_d_ff    <= 1'b0;
      dp_src_en_ff  <= 1'b0;
      dm_sink_en_ff <= 1'b0;
      dp_oe_ff      <= 1'b0;
      dm_oe_ff      <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      tmr_ff        <= nxt_tmr;
      kind_ff       <= nxt_kind; // R5
      stage_d_ff    <= stage_s;
      done_ff       <= (nxt_state == ST_DONE);
      dp_src_en_ff  <= (nxt_state == ST_SOURCE);
      dm_sink_en_ff <= (nxt_state == ST_SOURCE) | (nxt_state == ST_SECOND);
      // lines float outside active steps, always when disabled
      dp_oe_ff      <= det_en & ((nxt_state == ST_CONTACT) | (nxt_state == ST_SOURCE)); // R2
      dm_oe_ff      <= det_en & ((nxt_state == ST_SOURCE) | (nxt_state == ST_SECOND)); // R2
    end
  end

  // ==============================================================
  // downstream port power
  reg [2:0] oc_lock_ff;
  genvar gi;
  generate
    for (gi = 0; gi < `UCD_NPORTS; gi = gi + 1) begin : g_port
      wire ch_en = charge_en_ff[gi+1]; // R11 R8 R10
      always @(posedge aclk) begin
        if (!aresetn) begin
          port_power_bit[gi]   <= 1'b0;
          oc_lock_ff[gi]       <= 1'b0;
          charge_ack_en_ff[gi] <= 1'b0;
        end else begin
          // ack only; current switching is external
          charge_ack_en_ff[gi] <= ch_en & cfg_done; // R9 R10
          if (!overcurrent_sense_n_s[gi]) begin
            port_power_bit[gi] <= 1'b0; // R13
            oc_lock_ff[gi]     <= 1'b1; // R13
          end else if (hub_pwr) begin
            port_power_bit[gi] <= hub_power[gi]; // R12
          end else begin
            port_power_bit[gi] <= ch_en & cfg_done & ~oc_lock_ff[gi]; // R11 R12 R13
          end
        end
      end
    end
  endgenerate

  // ==============================================================
  // interrupts
  wire [1:0] irq_evt = {|(~overcurrent_sense_n_s & port_power_bit), done_evt};
  reg  [1:0] irq_clr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_ff <= 2'h0;
      irq_ff     <= 1'b0;
    end else begin
      // set wins over clear
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_evt; // R5
      irq_ff     <= |(irq_sts_ff & irq_en_ff); // R5
    end
  end

  // ==============================================================
  // axi4-lite slave
  reg        aw_hold_ff;
  reg        w_hold_ff;
  reg [7:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  wire       wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  reg [31:0] wmask;
  always @* begin
    wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    irq_clr = 2'h0;
    if (wr_go && awaddr_ff == `UCD_OFF_IRQ_CLEAR) begin
      irq_clr = wdata_ff[1:0] & wmask[1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      ctrl_ff       <= `UCD_CTRL_RST_VAL;
      irq_en_ff     <= 2'h0;
      charge_en_ff  <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_hold_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awaddr_ff)
          `UCD_OFF_CTRL:       ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask & 32'h0000_007f);
          `UCD_OFF_IRQ_ENABLE: irq_en_ff <= wmask[0] ? wdata_ff[1:0] : irq_en_ff;
          `UCD_OFF_CHARGE_EN:  charge_en_ff <= wmask[0] ? (wdata_ff[3:0] & 4'he) : charge_en_ff;
          `UCD_OFF_IRQ_CLEAR:  s_axi_bresp <= 2'h0;
          `UCD_OFF_STATUS:     s_axi_bresp <= 2'h0;
          `UCD_OFF_IRQ_STATUS: s_axi_bresp <= 2'h0;
          `UCD_OFF_PORT_POWER: s_axi_bresp <= 2'h0;
          default:             s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `UCD_OFF_CTRL:       s_axi_rdata <= ctrl_ff;
          `UCD_OFF_STATUS:     s_axi_rdata <= {21'h0, state_ff, done_ff, kind_ff}; // R5
          `UCD_OFF_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_sts_ff};
          `UCD_OFF_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
          `UCD_OFF_IRQ_ENABLE: s_axi_rdata <= {30'h0, irq_en_ff};
          `UCD_OFF_CHARGE_EN:  s_axi_rdata <= {28'h0, charge_en_ff};
          `UCD_OFF_PORT_POWER: s_axi_rdata <= {25'h0, oc_lock_ff, 1'b0, port_power_bit};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ucd_top

// file: testbench/ucd_charger_model.sv
// Purpose: upstream charger seen by the detection sequencer
// Assumes: mode 0 none, 1 shorted lines, 2 charging host port, 3 standard host port
// Notes:   comparators read 0 while no line is driven
`timescale 1ns/1ps
module ucd_charger_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] chg_mode,
  input  wire [7:0] chg_dly,
  input  wire       src_en,
  input  wire       sink_en,
  input  wire       dp_drive,
  output wire       contact_sense,
  output wire       dat_det_sense,
  output wire       short_sense
);
  reg [7:0] oe_cnt_ff;
  // slow contact: plug makes data contact chg_dly cycles late
  always @(posedge aclk) begin
    if (!aresetn || !dp_drive) oe_cnt_ff <= 8'h00;
    else if (oe_cnt_ff != 8'hff) oe_cnt_ff <= oe_cnt_ff + 8'h01;
  end
  assign contact_sense = (chg_mode != 2'h0) && dp_drive && (oe_cnt_ff >= chg_dly);
  assign short_sense   = (chg_mode == 2'h1) && sink_en;
  // charging host port reflects only while dp is sourced
  assign dat_det_sense = sink_en && ((chg_mode == 2'h1) || (chg_mode == 2'h2 && src_en));
endmodule // ucd_charger_model

// file: testbench/ucd_top_asserts.sv
// Purpose: port-level checks of the charger detection block
// Assumes: bench cycle counts of at least 4 for the end step
// Notes:   bound into ucd_top
`timescale 1ns/1ps
module ucd_chk #(
  parameter [31:0] CYC_CONTACT = 20,
  parameter [31:0] CYC_SOURCE  = 8
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [2:0]  overcurrent_sense_n,
  input wire        dp_src_en_ff,
  input wire        dm_sink_en_ff,
  input wire        dp_oe_ff,
  input wire        dm_oe_ff,
  input wire [2:0]  port_power_bit,
  input wire [2:0]  charge_ack_en_ff,
  input wire        irq_ff
);
  reg [31:0] src_cnt_ff;
  reg [31:0] con_cnt_ff;
  always @(posedge aclk) begin
    if (!aresetn || !dp_src_en_ff) src_cnt_ff <= 32'h0;
    else src_cnt_ff <= src_cnt_ff + 32'h1;
    if (!aresetn || !dp_oe_ff || dm_sink_en_ff) con_cnt_ff <= 32'h0;
    else con_cnt_ff <= con_cnt_ff + 32'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence src_run;
    dp_src_en_ff && dm_sink_en_ff && dp_oe_ff && dm_oe_ff;
  endsequence
  sequence lines_free;
    !dp_oe_ff && !dm_oe_ff && !dp_src_en_ff;
  endsequence
  AST_SRC_DRIVES: assert property (dp_src_en_ff |-> src_run)
    else $error("source step without both lines driven");
  AST_SRC_AFTER_CONTACT: assert property ($rose(dp_src_en_ff) |-> $past(dp_oe_ff))
    else $error("source step not preceded by contact step");
  AST_SRC_LEN: assert property ($fell(dp_src_en_ff) |-> src_cnt_ff == CYC_SOURCE)
    else $error("source step length wrong");
  AST_CONTACT_MAX: assert property (con_cnt_ff <= CYC_CONTACT)
    else $error("contact step overran its timeout");
  AST_END_FREE: assert property ($fell(dm_sink_en_ff) |-> lines_free [*4])
    else $error("lines driven during end delay");
  AST_RESET_QUIET: assert property ($rose(aresetn) |->
    port_power_bit == 3'h0 && charge_ack_en_ff == 3'h0 && !irq_ff && !dp_oe_ff)
    else $error("outputs not cleared by reset");
  AST_OC_CLEARS: assert property (!(|(port_power_bit & ~$past(overcurrent_sense_n, 3)
    & ~$past(overcurrent_sense_n, 4))))
    else $error("port powered through overcurrent");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule // ucd_chk
bind ucd_top ucd_chk #(.CYC_CONTACT(CYC_CONTACT), .CYC_SOURCE(CYC_SOURCE)) ucd_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .overcurrent_sense_n(overcurrent_sense_n),
  .dp_src_en_ff(dp_src_en_ff), .dm_sink_en_ff(dm_sink_en_ff), .dp_oe_ff(dp_oe_ff),
  .dm_oe_ff(dm_oe_ff), .port_power_bit(port_power_bit), .charge_ack_en_ff(charge_ack_en_ff),
  .irq_ff(irq_ff));

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the charger detection block
// Assumes: short timer parameters 20/8/8/5 cycles
// Notes:   bus handshakes are judged at the rising edge that takes them
`timescale 1ns/1ps
`include "ucd_regs.vh"
module tb_top;
  reg         aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  reg         arv = 1'b0, rready = 1'b0, stage = 1'b0, ga, slow = 1'b0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, dly = 8'h00;
  reg  [31:0] wdata = 32'h0, rdv;
  reg  [2:0]  ocn = 3'h7;
  reg  [1:0]  mode = 2'h0, rsp;
  wire        awr, wr, bv, arr, rv, cs, dd, ss, src, snk, dpo, dmo, irq;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  wire [2:0]  pw, ack;
  integer     n_mismatch = 0, check_count = 0, n, wt;
  ucd_top #(.CYC_CONTACT(20), .CYC_SOURCE(8), .CYC_END(8), .CYC_EXIT(5)) ucd_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .charger_detect_stage(stage),
    .contact_sense(cs), .dat_det_sense(dd), .short_sense(ss), .overcurrent_sense_n(ocn),
    .dp_src_en_ff(src), .dm_sink_en_ff(snk), .dp_oe_ff(dpo), .dm_oe_ff(dmo),
    .port_power_bit(pw), .charge_ack_en_ff(ack), .irq_ff(irq));
  ucd_charger_model ucd_charger_model_inst (.aclk(aclk), .aresetn(aresetn), .chg_mode(mode),
    .chg_dly(dly), .src_en(src), .sink_en(snk), .dp_drive(dpo), .contact_sense(cs),
    .dat_det_sense(dd), .short_sense(ss));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ==============================================================
  // common tasks
  task chk(input [31:0] s, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task tmo(input ok);
    if (!ok) n_mismatch = n_mismatch + 1;
  endtask
  // slow: ready raised only once the answer shows, so the slave must hold it
  task axwr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata  <= d;
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= ~slow;
      ga = 1'b0;
      for (wt = 0; wt < 100 && !ga; wt = wt + 1) begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wr) wv <= 1'b0;
        if (bv && bready) begin
          ga = 1'b1;
          rsp = br;
          bready <= 1'b0;
        end else if (bv) begin
          bready <= 1'b1;
        end
      end
      tmo(ga);
    end
  endtask
  task axrd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arv    <= 1'b1;
      rready <= ~slow;
      ga = 1'b0;
      for (wt = 0; wt < 100 && !ga; wt = wt + 1) begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
        if (rv && rready) begin
          ga = 1'b1;
          rdv = rd;
          rsp = rr;
          rready <= 1'b0;
        end else if (rv) begin
          rready <= 1'b1;
        end
      end
      tmo(ga);
    end
  endtask
  // ==============================================================
  // scenarios
  task t_regs;
    begin
      axrd(`UCD_OFF_CTRL); chk(rdv, `UCD_CTRL_RST_VAL);
      slow = 1'b1;
      axrd(8'h40); chk(rsp, 2'h2);
      axwr(8'h40, 32'h0); chk(rsp, 2'h2);
      slow = 1'b0;
    end
  endtask
  task t_det(input [1:0] m, input e, input [7:0] d, input [2:0] k);
    begin
      @(posedge aclk); mode <= m; dly <= d;
      axwr(`UCD_OFF_CTRL, {30'h0, e, 1'b1}); axwr(`UCD_OFF_IRQ_ENABLE, 32'h1);
      @(posedge aclk); stage <= 1'b1;
      rdv = 32'h0;
      for (n = 0; n < 100 && !rdv[3]; n = n + 1) axrd(`UCD_OFF_STATUS);
      chk(rdv[3:0], {1'b1, k});
      @(negedge aclk); chk(irq, 1'b1);
      axwr(`UCD_OFF_IRQ_CLEAR, 32'h1);
      repeat (2) @(negedge aclk); chk(irq, 1'b0);
      @(posedge aclk); stage <= 1'b0;
      repeat (8) @(posedge aclk);
    end
  endtask
  task t_off;
    begin
      axwr(`UCD_OFF_CTRL, 32'h0);
      @(posedge aclk); stage <= 1'b1;
      repeat (40) begin
        @(negedge aclk); chk({dpo, dmo}, 2'h0);
      end
      axrd(`UCD_OFF_STATUS); chk(rdv[3], 1'b0);
      @(posedge aclk); stage <= 1'b0; mode <= 2'h0;
      repeat (6) @(posedge aclk);
      axwr(`UCD_OFF_CTRL, 32'h1);
      @(posedge aclk); stage <= 1'b1;
      repeat (6) @(negedge aclk); chk(dpo, 1'b1);
      // abort in the contact step: no done event may follow
      axwr(`UCD_OFF_CTRL, 32'h0);
      @(negedge aclk); chk({dpo, dmo}, 2'h0);
      repeat (30) @(posedge aclk);
      axrd(`UCD_OFF_IRQ_STATUS); chk(rdv[0], 1'b0);
      @(posedge aclk); stage <= 1'b0;
      axwr(`UCD_OFF_CTRL, 32'h1);
    end
  endtask
  task t_pwr;
    begin
      axwr(`UCD_OFF_CHARGE_EN, 32'hb); axrd(`UCD_OFF_CHARGE_EN); chk(rdv, 32'ha);
      axwr(`UCD_OFF_CTRL, 32'h5);
      repeat (4) @(negedge aclk); chk(pw, 3'h5);
      chk(ack, 3'h5);
      @(posedge aclk); ocn <= 3'h6;
      repeat (4) @(posedge aclk); ocn <= 3'h7;
      repeat (8) @(negedge aclk); chk(pw, 3'h4);
      chk(irq, 1'b0);
      axrd(`UCD_OFF_IRQ_STATUS); chk(rdv[1], 1'b1);
      axwr(`UCD_OFF_IRQ_ENABLE, 32'h3);
      repeat (2) @(negedge aclk); chk(irq, 1'b1);
      axwr(`UCD_OFF_IRQ_CLEAR, 32'h2);
      axwr(`UCD_OFF_CTRL, 32'h7d); repeat (2) @(negedge aclk); chk(pw, 3'h7);
      axwr(`UCD_OFF_CTRL, 32'h2d); repeat (2) @(negedge aclk); chk(pw, 3'h2);
      @(posedge aclk); aresetn <= 1'b0;
      repeat (20) @(posedge aclk); aresetn <= 1'b1;
      @(negedge aclk); chk(pw, 3'h0);
      axwr(`UCD_OFF_CHARGE_EN, 32'h2); axwr(`UCD_OFF_CTRL, 32'h5);
      repeat (2) @(negedge aclk); chk(pw, 3'h1);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_det(2'h1, 1'b0, 8'h0, `UCD_KIND_DCP);
    t_det(2'h3, 1'b0, 8'h0, `UCD_KIND_SDP);
    t_det(2'h2, 1'b1, 8'h3, `UCD_KIND_CDP);
    t_det(2'h1, 1'b1, 8'h5, `UCD_KIND_DCP);
    t_det(2'h2, 1'b0, 8'h0, `UCD_KIND_DCP);
    t_det(2'h0, 1'b0, 8'h0, `UCD_KIND_SDP);
    t_det(2'h3, 1'b1, 8'h0, `UCD_KIND_SDP);
    t_off;
    t_pwr;
    final_report;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // tb_top
